//--- src/lpmc_pkg.sv
package lpmc_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLKSRC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // ************************************************************
   // control and clock-source register fields
   // ************************************************************
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int FILT_LSB = 2;
   localparam int FILT_W = 6;
   localparam int RAMSEL_LSB = 8;
   localparam int RAMSEL_W = 2;
   localparam int FLASH_OFF_BIT = 10;
   localparam int KEEPALIVE_BIT = 0;

   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [5:0] FILT_RST = 6'h00;
   localparam logic [1:0] RAMSEL_RST = 2'h0;
   localparam logic [1:0] RAMSEL_KEEP = 2'h0;
   localparam logic [1:0] RAMSEL_OFF = 2'h1;

   // ************************************************************
   // mode select and states
   // ************************************************************
   typedef enum logic [1:0] {
      LPMC_SEL_IDLE = 2'h0,
      LPMC_SEL_STANDBY = 2'h1,
      LPMC_SEL_HALT = 2'h2,
      LPMC_SEL_HIBERNATE = 2'h3
   } lpmc_sel_t;

   typedef enum logic [2:0] {
      LPMC_RUN = 3'h0,
      LPMC_LOW = 3'h1,
      LPMC_WAKE_CLK = 3'h3,
      LPMC_WAKE_CORE = 3'h2,
      LPMC_HIBER = 3'h6
   } lpmc_state_t;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int IDLE_GUARD_CYC = 5;
   localparam int STANDBY_FILT_BASE = 2;

endpackage : lpmc_pkg

//--- src/lpmc_top.sv
`timescale 1ns/100ps
module lpmc_top #(
   parameter int FILT_W = 6
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu and wake events
   input wire logic idle_instr_i,
   input wire logic enabled_interrupt_i,
   input wire logic watchdog_interrupt_i,
   input wire logic external_reset_pin_i,
   input wire logic pll_powered_i,
   // clock enables
   output logic cpu_input_clock_en_o,
   output logic cpu_system_clock_en_o,
   output logic cpu_core_clock_en_o,
   output logic peripheral_clock_en_o,
   output logic watchdog_clock_en_o,
   output logic auxiliary_pll_clock_en_o,
   // power controls
   output logic internal_osc_one_pwr_o,
   output logic internal_osc_two_pwr_o,
   output logic crystal_pins_osc_pwr_o,
   output logic flash_pwr_o,
   output logic low_ram_pwr_o,
   output logic dedicated_local_global_rams_pwr_o,
   output logic periph_pwr_o,
   output logic analog_low_power_o,
   output logic io_hold_o,
   output logic pll_violation_o
);

   initial begin
      if (FILT_W != 6) begin
         $error("lpmc_top: FILT_W must be 6");
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   logic [1:0] mode_sel;
   logic [FILT_W-1:0] standby_wake_filter_len;
   logic [1:0] low_ram_hibernate_select;
   logic flash_off_in_halt;
   logic watchdog_halt_keepalive;
   lpmc_pkg::lpmc_state_t state;
   lpmc_pkg::lpmc_state_t next_state;
   lpmc_pkg::lpmc_sel_t active_mode;
   logic [2:0] guard_cnt;
   logic wake_raw;
   logic wake_qual;
   logic wake_ok;
   logic access;
   logic [31:0] next_rdata;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ************************************************************
   // control and clock-source register writes
   // ************************************************************
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_new;
   logic [31:0] clksrc_new;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[lpmc_pkg::MODE_LSB +: lpmc_pkg::MODE_W] = mode_sel;
      ctrl_word[lpmc_pkg::FILT_LSB +: FILT_W] = standby_wake_filter_len;
      ctrl_word[lpmc_pkg::RAMSEL_LSB +: lpmc_pkg::RAMSEL_W] =
         low_ram_hibernate_select;
      ctrl_word[lpmc_pkg::FLASH_OFF_BIT] = flash_off_in_halt;
   end

   assign ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i);
   assign clksrc_new = merge({31'h0, watchdog_halt_keepalive}, wb_dat_i,
      wb_sel_i);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_sel <= lpmc_pkg::MODE_RST;
         standby_wake_filter_len <= lpmc_pkg::FILT_RST;
         low_ram_hibernate_select <= lpmc_pkg::RAMSEL_RST;
         flash_off_in_halt <= 1'b0;
         watchdog_halt_keepalive <= 1'b0;
      end else if (access && wb_we_i) begin
         if (wb_adr_i == lpmc_pkg::ADDR_CTRL) begin
            mode_sel <= ctrl_new[lpmc_pkg::MODE_LSB +: lpmc_pkg::MODE_W];
            standby_wake_filter_len <=
               ctrl_new[lpmc_pkg::FILT_LSB +: FILT_W];
            low_ram_hibernate_select <=
               ctrl_new[lpmc_pkg::RAMSEL_LSB +: lpmc_pkg::RAMSEL_W];
            flash_off_in_halt <= ctrl_new[lpmc_pkg::FLASH_OFF_BIT];
         end else if (wb_adr_i == lpmc_pkg::ADDR_CLKSRC) begin
            watchdog_halt_keepalive <= clksrc_new[lpmc_pkg::KEEPALIVE_BIT];
         end
      end
   end

   // ************************************************************
   // bus read and ack
   // ************************************************************
   always_comb begin
      next_rdata = '0;
      if (wb_adr_i == lpmc_pkg::ADDR_CTRL) begin
         next_rdata = ctrl_word;
      end else if (wb_adr_i == lpmc_pkg::ADDR_CLKSRC) begin
         next_rdata = {31'h0, watchdog_halt_keepalive};
      end else if (wb_adr_i == lpmc_pkg::ADDR_STATUS) begin
         next_rdata = {26'h0, pll_violation_o, active_mode, state};
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? next_rdata : 32'h0;
      end
   end

   // ************************************************************
   // wake sources
   // ************************************************************
   assign wake_raw = enabled_interrupt_i || watchdog_interrupt_i ||
      external_reset_pin_i;

   lpmc_wake_filter #(
      .LEN_W(FILT_W)
   ) u_filter (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .enable_i(state == lpmc_pkg::LPMC_LOW &&
         active_mode == lpmc_pkg::LPMC_SEL_STANDBY),
      .len_i(standby_wake_filter_len),
      .wake_i(wake_raw),
      .wake_o(wake_qual)
   );

   always_comb begin
      wake_ok = 1'b0;
      if (active_mode == lpmc_pkg::LPMC_SEL_STANDBY) begin
         wake_ok = wake_qual;
      end else if (guard_cnt >= 3'(lpmc_pkg::IDLE_GUARD_CYC)) begin
         wake_ok = wake_raw;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || state != lpmc_pkg::LPMC_LOW) begin
         guard_cnt <= '0;
      end else if (guard_cnt < 3'(lpmc_pkg::IDLE_GUARD_CYC)) begin
         guard_cnt <= guard_cnt + 3'h1;
      end
   end

   // ************************************************************
   // mode state machine
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         lpmc_pkg::LPMC_RUN: begin
            if (idle_instr_i) begin
               if (mode_sel == lpmc_pkg::LPMC_SEL_HIBERNATE) begin
                  next_state = lpmc_pkg::LPMC_HIBER;
               end else begin
                  next_state = lpmc_pkg::LPMC_LOW;
               end
            end
         end
         lpmc_pkg::LPMC_LOW: begin
            if (wake_ok) begin
               next_state = lpmc_pkg::LPMC_WAKE_CLK;
            end
         end
         lpmc_pkg::LPMC_WAKE_CLK: next_state = lpmc_pkg::LPMC_WAKE_CORE;
         lpmc_pkg::LPMC_WAKE_CORE: next_state = lpmc_pkg::LPMC_RUN;
         lpmc_pkg::LPMC_HIBER: begin
            if (wake_raw) begin
               next_state = lpmc_pkg::LPMC_WAKE_CLK;
            end
         end
         default: next_state = lpmc_pkg::LPMC_RUN;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state <= lpmc_pkg::LPMC_RUN;
         active_mode <= lpmc_pkg::LPMC_SEL_IDLE;
      end else begin
         state <= next_state;
         if (state == lpmc_pkg::LPMC_RUN && idle_instr_i) begin
            active_mode <= lpmc_pkg::lpmc_sel_t'(mode_sel);
         end
      end
   end

   // ************************************************************
   // clock and power outputs
   // ************************************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cpu_input_clock_en_o <= 1'b1;
         cpu_system_clock_en_o <= 1'b1;
         cpu_core_clock_en_o <= 1'b1;
         peripheral_clock_en_o <= 1'b1;
         watchdog_clock_en_o <= 1'b1;
         auxiliary_pll_clock_en_o <= 1'b1;
         internal_osc_one_pwr_o <= 1'b1;
         internal_osc_two_pwr_o <= 1'b1;
         crystal_pins_osc_pwr_o <= 1'b1;
         flash_pwr_o <= 1'b1;
         low_ram_pwr_o <= 1'b1;
         dedicated_local_global_rams_pwr_o <= 1'b1;
         periph_pwr_o <= 1'b1;
         analog_low_power_o <= 1'b0;
         io_hold_o <= 1'b0;
         pll_violation_o <= 1'b0;
      end else begin
         cpu_input_clock_en_o <= 1'b1;
         cpu_system_clock_en_o <= 1'b1;
         cpu_core_clock_en_o <= 1'b1;
         peripheral_clock_en_o <= 1'b1;
         watchdog_clock_en_o <= 1'b1;
         auxiliary_pll_clock_en_o <= 1'b1;
         internal_osc_one_pwr_o <= 1'b1;
         internal_osc_two_pwr_o <= 1'b1;
         crystal_pins_osc_pwr_o <= 1'b1;
         flash_pwr_o <= 1'b1;
         low_ram_pwr_o <= 1'b1;
         dedicated_local_global_rams_pwr_o <= 1'b1;
         periph_pwr_o <= 1'b1;
         analog_low_power_o <= 1'b0;
         io_hold_o <= 1'b0;
         if (state == lpmc_pkg::LPMC_RUN && idle_instr_i &&
               mode_sel == lpmc_pkg::LPMC_SEL_HALT && pll_powered_i) begin
            pll_violation_o <= 1'b1;
         end else if (state == lpmc_pkg::LPMC_WAKE_CORE) begin
            pll_violation_o <= 1'b0;
         end
         case (next_state)
            lpmc_pkg::LPMC_LOW: begin
               cpu_core_clock_en_o <= 1'b0;
               if ((state == lpmc_pkg::LPMC_RUN ? mode_sel :
                     active_mode) !=
                     lpmc_pkg::LPMC_SEL_IDLE) begin
                  cpu_input_clock_en_o <= 1'b0;
                  cpu_system_clock_en_o <= 1'b0;
                  peripheral_clock_en_o <= 1'b0;
               end
               if ((state == lpmc_pkg::LPMC_RUN ? mode_sel : active_mode)
                     == lpmc_pkg::LPMC_SEL_HALT) begin
                  auxiliary_pll_clock_en_o <= 1'b0;
                  crystal_pins_osc_pwr_o <= 1'b0;
                  flash_pwr_o <= !flash_off_in_halt;
                  watchdog_clock_en_o <= watchdog_halt_keepalive;
                  internal_osc_one_pwr_o <= watchdog_halt_keepalive;
                  internal_osc_two_pwr_o <= watchdog_halt_keepalive;
               end
            end
            lpmc_pkg::LPMC_WAKE_CLK: begin
               cpu_core_clock_en_o <= 1'b0;
            end
            lpmc_pkg::LPMC_HIBER: begin
               cpu_input_clock_en_o <= 1'b0;
               cpu_system_clock_en_o <= 1'b0;
               cpu_core_clock_en_o <= 1'b0;
               peripheral_clock_en_o <= 1'b0;
               periph_pwr_o <= 1'b0;
               watchdog_clock_en_o <= 1'b0;
               auxiliary_pll_clock_en_o <= 1'b0;
               internal_osc_one_pwr_o <= 1'b0;
               internal_osc_two_pwr_o <= 1'b0;
               crystal_pins_osc_pwr_o <= 1'b0;
               flash_pwr_o <= 1'b0;
               analog_low_power_o <= 1'b1;
               low_ram_pwr_o <= (low_ram_hibernate_select ==
                  lpmc_pkg::RAMSEL_KEEP);
               dedicated_local_global_rams_pwr_o <= 1'b0;
               io_hold_o <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

endmodule : lpmc_top

//--- src/lpmc_wake_filter.sv
`timescale 1ns/100ps
module lpmc_wake_filter #(
   parameter int LEN_W = 6
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic [LEN_W-1:0] len_i,
   input wire logic wake_i,
   output logic wake_o
);
   localparam int CNT_W = LEN_W + 2;

   initial begin
      if (LEN_W < 1) begin
         $error("lpmc_wake_filter: LEN_W must be at least 1");
      end
   end

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] need;

   assign need = CNT_W'(len_i) + CNT_W'(lpmc_pkg::STANDBY_FILT_BASE);

   // ************************************************************
   // wake must be stable for (base + length) cycles
   // ************************************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !enable_i || !wake_i) begin
         count <= '0;
         wake_o <= 1'b0;
      end else if (count + CNT_W'(1) >= need) begin
         wake_o <= 1'b1;
      end else begin
         count <= count + CNT_W'(1);
      end
   end

endmodule : lpmc_wake_filter

//--- testbench/lpmc_assertions.sv
`timescale 1ns/100ps
module lpmc_assertions #(
   parameter int FILT_W = 6
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic idle_instr_i,
   input wire logic enabled_interrupt_i,
   input wire logic watchdog_interrupt_i,
   input wire logic external_reset_pin_i,
   input wire logic pll_powered_i,
   input wire logic cpu_input_clock_en_o,
   input wire logic cpu_system_clock_en_o,
   input wire logic cpu_core_clock_en_o,
   input wire logic peripheral_clock_en_o,
   input wire logic watchdog_clock_en_o,
   input wire logic auxiliary_pll_clock_en_o,
   input wire logic internal_osc_one_pwr_o,
   input wire logic internal_osc_two_pwr_o,
   input wire logic crystal_pins_osc_pwr_o,
   input wire logic flash_pwr_o,
   input wire logic low_ram_pwr_o,
   input wire logic dedicated_local_global_rams_pwr_o,
   input wire logic periph_pwr_o,
   input wire logic analog_low_power_o,
   input wire logic io_hold_o,
   input wire logic pll_violation_o
);
   // ************************************************************
   // shadow of the mode fields
   // ************************************************************
   logic [1:0] mode;
   logic [1:0] ramsel;
   logic flash_off;
   logic keep;
   logic go;
   logic wake;
   assign go = idle_instr_i && cpu_core_clock_en_o && !io_hold_o;
   assign wake = enabled_interrupt_i || watchdog_interrupt_i
      || external_reset_pin_i;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode <= lpmc_pkg::MODE_RST;
         ramsel <= lpmc_pkg::RAMSEL_RST;
         flash_off <= 1'b0;
         keep <= 1'b0;
      end else if (wb_ack_o && wb_we_i) begin
         if (wb_adr_i == lpmc_pkg::ADDR_CTRL && wb_sel_i[0]) begin
            mode <= wb_dat_i[1:0];
         end
         if (wb_adr_i == lpmc_pkg::ADDR_CTRL && wb_sel_i[1]) begin
            ramsel <= wb_dat_i[9:8];
            flash_off <= wb_dat_i[10];
         end
         if (wb_adr_i == lpmc_pkg::ADDR_CLKSRC && wb_sel_i[0]) begin
            keep <= wb_dat_i[0];
         end
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_idle_gate;
      go && mode == 2'h0 |=> !cpu_core_clock_en_o && cpu_input_clock_en_o
         && cpu_system_clock_en_o && peripheral_clock_en_o
         && watchdog_clock_en_o && auxiliary_pll_clock_en_o;
   endproperty
   a_idle_gate: assert property (p_idle_gate)
      else $error("idle gating wrong");
   property p_stby_gate;
      go && mode == 2'h1 |=> !cpu_input_clock_en_o && !cpu_core_clock_en_o
         && !cpu_system_clock_en_o && !peripheral_clock_en_o
         && watchdog_clock_en_o && auxiliary_pll_clock_en_o;
   endproperty
   a_stby_gate: assert property (p_stby_gate)
      else $error("standby gating wrong");
   property p_halt_gate;
      go && mode == 2'h2 |=> !(cpu_input_clock_en_o || cpu_system_clock_en_o
         || peripheral_clock_en_o || auxiliary_pll_clock_en_o)
         && !crystal_pins_osc_pwr_o && flash_pwr_o == !flash_off;
   endproperty
   a_halt_gate: assert property (p_halt_gate)
      else $error("halt gating wrong");
   property p_halt_keep;
      go && mode == 2'h2 |=> watchdog_clock_en_o == keep
         && internal_osc_one_pwr_o == keep && internal_osc_two_pwr_o == keep;
   endproperty
   a_halt_keep: assert property (p_halt_keep)
      else $error("halt keep-alive wrong");
   property p_hiber;
      go && mode == 2'h3 |=> io_hold_o && analog_low_power_o && !periph_pwr_o
         && !dedicated_local_global_rams_pwr_o
         && low_ram_pwr_o == (ramsel == 2'h0);
   endproperty
   a_hiber: assert property (p_hiber)
      else $error("hibernate power wrong");
   property p_wake_order;
      $rose(cpu_core_clock_en_o) |-> $past(cpu_system_clock_en_o)
         && $past(peripheral_clock_en_o) && $past(cpu_input_clock_en_o);
   endproperty
   a_wake_order: assert property (p_wake_order)
      else $error("core clock back before others");
   property p_idle_guard;
      go && mode == 2'h0 |=> !cpu_core_clock_en_o [*7];
   endproperty
   a_idle_guard: assert property (p_idle_guard)
      else $error("idle left inside guard");
   property p_idle_exit;
      go && mode == 2'h0 ##1 wake [*7] |-> ##[0:2] cpu_core_clock_en_o;
   endproperty
   a_idle_exit: assert property (p_idle_exit)
      else $error("idle not left on wake");
   property p_stby_qual;
      $rose(cpu_system_clock_en_o) && mode == 2'h1 |-> $past(wake)
         && $past(wake, 2);
   endproperty
   a_stby_qual: assert property (p_stby_qual)
      else $error("standby left on short wake");
   property p_pll;
      go && mode == 2'h2 && pll_powered_i |=> pll_violation_o;
   endproperty
   a_pll: assert property (p_pll)
      else $error("pll flag not raised");
endmodule : lpmc_assertions

bind lpmc_top lpmc_assertions #(.FILT_W(FILT_W)) u_chk (.*);

//--- testbench/lpmc_top_tb.sv
`timescale 1ns/100ps
module lpmc_top_tb;
   logic clock_i = 1'b0, rst_n_i = 1'b0, idle_instr_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [2:0] wk = 3'h0;
   logic pll_powered_i = 1'b0, wb_ack_o, c_in, c_sys, c_core, c_per, c_wd;
   logic c_aux, p_o1, p_o2, p_xt, p_fl, p_lr, p_dlg, p_per, p_an, p_hold;
   logic pll_violation_o;
   logic [14:0] vec;
   int err_total = 0, num_checks = 0, cyc = 0;
   assign vec = {c_in, c_sys, c_core, c_per, c_wd, c_aux, p_o1, p_o2,
      p_xt, p_fl, p_lr, p_dlg, p_per, p_an, p_hold};
   lpmc_top #(.FILT_W(6)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .idle_instr_i(idle_instr_i),
      .enabled_interrupt_i(wk[0]), .watchdog_interrupt_i(wk[1]),
      .external_reset_pin_i(wk[2]), .pll_powered_i(pll_powered_i),
      .cpu_input_clock_en_o(c_in), .cpu_system_clock_en_o(c_sys),
      .cpu_core_clock_en_o(c_core), .peripheral_clock_en_o(c_per),
      .watchdog_clock_en_o(c_wd), .auxiliary_pll_clock_en_o(c_aux),
      .internal_osc_one_pwr_o(p_o1), .internal_osc_two_pwr_o(p_o2),
      .crystal_pins_osc_pwr_o(p_xt), .flash_pwr_o(p_fl),
      .low_ram_pwr_o(p_lr), .dedicated_local_global_rams_pwr_o(p_dlg),
      .periph_pwr_o(p_per), .analog_low_power_o(p_an), .io_hold_o(p_hold),
      .pll_violation_o(pll_violation_o));
   // ************************************************************
   // clock, timeout and helpers
   // ************************************************************
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clock_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) chk("bus ack", 1, 0);
   endtask : wb_xfer
   function automatic logic [14:0] exp_vec(input logic [1:0] md,
      input logic kp, input logic ro, input logic fo);
      logic [14:0] e;
      e = 15'h7FFC;
      case (md)
         2'h0: e[12] = 1'b0;
         2'h1: e[14:11] = 4'h0;
         2'h2: begin
            e[14:9] = {4'h0, kp, 1'b0};
            e[8:5] = {kp, kp, 1'b0, !fo};
         end
         default: e[4:0] = {!ro, 4'h3};
      endcase
      return e;
   endfunction : exp_vec
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [31:0] q, cw;
      logic [14:0] msk;
      logic [1:0] md;
      logic kp, ro, fo;
      int n;
      void'($urandom(32'h9105F141));
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(negedge clock_i);
      chk("reset outputs", 32'h7FFC, vec);
      wb_xfer(1'b0, lpmc_pkg::ADDR_STATUS, 32'h0, q);
      chk("status reset", 32'h0, q[5:0]);
      wb_xfer(1'b1, 8'h0C, $urandom, q);
      wb_xfer(1'b0, 8'h0C, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      for (int m = 0; m < 6; m++) begin
         md = (m == 4) ? 2'h2 : (m == 5) ? 2'h0 : m[1:0];
         kp = (m == 4);
         ro = 1'($urandom_range(0, 1));
         fo = 1'($urandom_range(0, 1));
         msk = (md == 2'h3) ? 15'h001F : 15'h7FFF;
         cw = {21'h0, fo, 1'b0, ro, 6'($urandom_range(0, 7)), md};
         wb_xfer(1'b1, lpmc_pkg::ADDR_CTRL, cw, q);
         wb_xfer(1'b0, lpmc_pkg::ADDR_CTRL, 32'h0, q);
         chk("ctrl readback", cw, {21'h0, q[10:0]});
         wb_xfer(1'b1, lpmc_pkg::ADDR_CLKSRC, {31'h0, kp}, q);
         wb_xfer(1'b0, lpmc_pkg::ADDR_CLKSRC, 32'h0, q);
         chk("keep-alive readback", kp, q[0]);
         pll_powered_i <= (m == 2);
         @(posedge clock_i);
         idle_instr_i <= 1'b1;
         @(posedge clock_i);
         idle_instr_i <= 1'b0;
         if (md == 2'h0) wk <= 3'h1 << (m % 3);
         @(negedge clock_i);
         chk("gated outputs", exp_vec(md, kp, ro, fo) & msk, vec & msk);
         chk("pll flag set", m == 2, pll_violation_o);
         if (md == 2'h0) begin
            repeat (5) @(posedge clock_i);
            @(negedge clock_i);
            chk("core held in guard", 0, c_core);
         end else begin
            wb_xfer(1'b0, lpmc_pkg::ADDR_STATUS, 32'h0, q);
            chk("status low", {md, (md == 2'h3) ? 3'h6 : 3'h1}, q[4:0]);
            wk <= 3'h1 << (m % 3);
         end
         n = 0;
         while (c_core !== 1'b1 && n < 300) begin
            @(posedge clock_i);
            n++;
         end
         if (md == 2'h1) begin
            chk("standby wake cycles", 32'(cw[7:2]) + 32'h5, n);
         end
         @(negedge clock_i);
         chk("woken outputs", 32'h7FFC, vec);
         chk("pll flag clear", 0, pll_violation_o);
         @(posedge clock_i);
         wk <= 3'h0;
         repeat (2) @(posedge clock_i);
      end
      tally_and_finish();
   end
endmodule : lpmc_top_tb
